// >>> src/dcs_pkg.sv
/*
 * Shared constants for the daisy-chain shift and readback block:
 * shift register length, field positions, widths and reset values.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package dcs_pkg;

    // Shift register geometry
    localparam int unsigned SR_LEN     = 17;
    localparam int unsigned WIPER_W    = 8;
    localparam int unsigned CNT_W      = 5;

    // Field positions in the physical register (first bit shifted in ends at the top)
    localparam int unsigned STACK_POS  = 16;
    localparam int unsigned W1_MSB     = 15;
    localparam int unsigned W1_LSB     = 8;
    localparam int unsigned W0_MSB     = 7;
    localparam int unsigned W0_LSB     = 0;
    localparam int unsigned OUT_POS    = 16;

    // Bit counter wrap value, one whole device frame
    localparam logic [4:0]  LAST_BIT   = 5'h10;

    // Values after reset
    localparam logic [16:0] SR_RST     = 17'h0_0000;
    localparam logic [7:0]  WIPER_RST  = 8'h00;
    localparam logic [4:0]  CNT_RST    = 5'h00;
    localparam logic [2:0]  SYNC_RST   = 3'h0;

    // Serial port phase
    typedef enum logic {
        PH_IDLE,
        PH_SHIFT
    } dcs_phase_e;

endpackage

`default_nettype wire

// >>> src/dcs_sync.sv
/*
 * Two-flop synchroniser for the three serial port pins.
 * Assumes the pins are asynchronous to core_clk.
 */
`default_nettype none

module dcs_sync
    import dcs_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Raw pins and synchronised copies
    input  wire logic [2:0] pinRaw,
    output logic      [2:0] pinSync
);

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } dcs_sync_s;

    dcs_sync_s syncR_r;
    dcs_sync_s syncR_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: first stage only feeds the second
    always_comb begin
        syncR_nxt        = syncR_r;
        syncR_nxt.stage1 = pinRaw;
        syncR_nxt.stage2 = syncR_r.stage1;
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            syncR_r <= '{stage1: SYNC_RST, stage2: SYNC_RST};
        end else begin
            syncR_r <= syncR_nxt;
        end
    end

    assign pinSync = syncR_r.stage2;

endmodule

`default_nettype wire

// >>> src/dcs_shift_readback.sv
/*
 * Daisy-chainable 17-bit serial shift register with cascade output,
 * wiper and stack-select holding registers and the stacked wiper select.
 * Assumes a controller drives portEn, serClk and serData asynchronously
 * to core_clk, with serClk much slower than core_clk (8x or more).
 */
`default_nettype none

module dcs_shift_readback
    import dcs_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Serial port pins
    input  wire logic       portEn,
    input  wire logic       serClk,
    input  wire logic       serData,
    // Cascade output
    output logic            cascadeOut,
    // Holding registers, stacked select and frame alignment flag
    output logic [7:0]      wiperZero,
    output logic [7:0]      wiperOne,
    output logic            stackSel,
    output logic [7:0]      stackedWiper,
    output logic            frameAligned
);

    typedef struct packed {
        dcs_phase_e  phase;
        logic        clkPrev;
        logic [16:0] shiftReg;
        logic [4:0]  bitCnt;
        logic        aligned;
        logic [7:0]  wZero;
        logic [7:0]  wOne;
        logic        sSel;
        logic        cout;
        logic [16:0] snap;
        logic        feedOk;
    } dcs_state_s;

    dcs_state_s st_r;
    dcs_state_s st_nxt;
    logic [2:0] pinSync;
    logic       enS;
    logic       clkS;
    logic       dataS;
    logic       enRise;
    logic       enFall;
    logic       clkRise;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    dcs_sync u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pinRaw   ({portEn, serClk, serData}),
        .pinSync  (pinSync)
    );

    assign enS   = pinSync[2];
    assign clkS  = pinSync[1];
    assign dataS = pinSync[0];

    // Edge detection on synchronised pins, shifting only while enabled
    assign enRise  = enS && (st_r.phase == PH_IDLE);
    assign enFall  = !enS && (st_r.phase == PH_SHIFT);
    assign clkRise = enS && (st_r.phase == PH_SHIFT) && clkS && !st_r.clkPrev;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt         = st_r;
        st_nxt.clkPrev = clkS;
        case (st_r.phase)
            PH_IDLE: begin
                if (enRise) begin
                    st_nxt.phase   = PH_SHIFT;
                    st_nxt.bitCnt  = CNT_RST;
                    st_nxt.aligned = 1'b1;
                end
            end
            PH_SHIFT: begin
                if (!enS) begin
                    // Commit the register to the holding registers
                    st_nxt.phase = PH_IDLE;
                    st_nxt.sSel  = st_r.shiftReg[STACK_POS];
                    st_nxt.wOne  = st_r.shiftReg[W1_MSB:W1_LSB];
                    st_nxt.wZero = st_r.shiftReg[W0_MSB:W0_LSB];
                end else if (clkRise) begin
                    // Capture at position 0, far end moves out
                    st_nxt.shiftReg = {st_r.shiftReg[SR_LEN-2:0], dataS};
                    if (st_r.bitCnt == LAST_BIT) begin
                        st_nxt.bitCnt  = CNT_RST;
                        st_nxt.aligned = 1'b1;
                    end else begin
                        st_nxt.bitCnt  = 5'(st_r.bitCnt + 5'h01);
                        st_nxt.aligned = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt.phase = PH_IDLE;
            end
        endcase
        // Rotation tracking for the full-circle check: snapshot at frame start
        // and at every frame boundary, and note whether every bit taken in before the frame's last
        // was the bit that left the far end, as it is with the feedback loop closed
        if (enRise) begin
            st_nxt.snap   = st_r.shiftReg;
            st_nxt.feedOk = 1'b1;
        end else if (clkRise) begin
            if (st_r.bitCnt == LAST_BIT) begin
                st_nxt.snap   = st_nxt.shiftReg;
                st_nxt.feedOk = 1'b1;
            end else begin
                st_nxt.feedOk = st_r.feedOk && (dataS == st_r.shiftReg[OUT_POS]);
            end
        end
        // Cascade pin always driven: far end while active, select bit when idle
        if (st_nxt.phase == PH_SHIFT) begin
            st_nxt.cout = st_nxt.shiftReg[OUT_POS];
        end else begin
            st_nxt.cout = st_nxt.sSel;
        end
    end

    // Register the state; holding registers cleared here only for determinism
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r.phase    <= PH_IDLE;
            st_r.clkPrev  <= 1'b0;
            st_r.shiftReg <= SR_RST;
            st_r.bitCnt   <= CNT_RST;
            st_r.aligned  <= 1'b1;
            st_r.wZero    <= WIPER_RST;
            st_r.wOne     <= WIPER_RST;
            st_r.sSel     <= 1'b0;
            st_r.cout     <= 1'b0;
            st_r.snap     <= SR_RST;
            st_r.feedOk   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign cascadeOut   = st_r.cout;
    assign wiperZero    = st_r.wZero;
    assign wiperOne     = st_r.wOne;
    assign stackSel     = st_r.sSel;
    assign frameAligned = st_r.aligned;
    assign stackedWiper = st_r.sSel ? st_r.wOne : st_r.wZero;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_shift_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
        clkRise |=> (st_r.shiftReg == {$past(st_r.shiftReg[15:0]), $past(dataS)}))
        else $error("Shift register did not capture and advance");

    a_cascade_active: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.phase == PH_SHIFT) |-> (cascadeOut == st_r.shiftReg[16]))
        else $error("Cascade output not the far end while active");

    a_cascade_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.phase == PH_IDLE) |-> (cascadeOut == stackSel))
        else $error("Cascade output not the select bit while idle");

    a_load_on_fall: assert property (@(posedge core_clk) disable iff (!reset_n)
        enFall |=> (stackSel == $past(st_r.shiftReg[16])) &&
                   (wiperOne == $past(st_r.shiftReg[15:8])) &&
                   (wiperZero == $past(st_r.shiftReg[7:0])))
        else $error("Holding registers not loaded on enable fall");

    a_holding_stable: assert property (@(posedge core_clk) disable iff (!reset_n)
        !enFall |=> $stable(wiperZero) && $stable(wiperOne) && $stable(stackSel))
        else $error("Holding register changed outside enable fall");

    a_ignore_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!enS ##1 !enS) |=> $stable(st_r.shiftReg))
        else $error("Register moved while port disabled");

    a_stack_mux: assert property (@(posedge core_clk) disable iff (!reset_n)
        stackSel |-> (stackedWiper == wiperOne))
        else $error("Stacked wiper does not follow select bit one");

    a_rotate_home: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clkRise && (st_r.bitCnt == LAST_BIT) && st_r.feedOk &&
         (dataS == st_r.shiftReg[16])) |=>
        (st_r.shiftReg == $past(st_r.snap)) && frameAligned)
        else $error("Full rotation did not restore register");

    a_count_range: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.bitCnt <= LAST_BIT))
        else $error("Bit counter ran past one device frame");

    c_full_frame: cover property (@(posedge core_clk) disable iff (!reset_n)
        enFall && st_r.aligned && (st_r.bitCnt == CNT_RST));

    c_rotation: cover property (@(posedge core_clk) disable iff (!reset_n)
        clkRise && (st_r.bitCnt == LAST_BIT) && st_r.feedOk);

    c_stack_one: cover property (@(posedge core_clk) disable iff (!reset_n)
        enFall ##1 stackSel);

    c_partial_frame: cover property (@(posedge core_clk) disable iff (!reset_n)
        enFall && !st_r.aligned);

endmodule

`default_nettype wire

// >>> verification/dcs_ctl_model.sv
/*
 * Behavioural controller for the three-wire serial port: enable, clock, data.
 * Assumes core_clk runs the bench; pins change only at its falling edge, except serData, which follows cascadeIn in feedback mode.
 */
`default_nettype none

module dcs_ctl_model (
    // Bench timing and feedback from the last cascade output
    input  wire logic core_clk,
    input  wire logic cascadeIn,
    // Serial port pins
    output logic      portEn,
    output logic      serClk,
    output logic      serData
);
    timeunit 1ns;
    timeprecision 1ps;

    logic fbMode;
    logic dBit;

    // Data line is released to the cascade loop in feedback mode
    assign serData = fbMode ? cascadeIn : dBit;

    initial begin
        portEn = 1'b0;
        serClk = 1'b0;
        fbMode = 1'b0;
        dBit   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic waitc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Rising enable starts a transaction, first clock well after it
    task automatic open_frame();
        waitc(1);
        portEn = 1'b1;
        waitc(4);
    endtask

    // One 200 ns serial clock, data held around the rising edge
    task automatic clk_bit(input logic b);
        dBit = b;
        waitc(4);
        serClk = 1'b1;
        waitc(4);
        serClk = 1'b0;
    endtask

    // Enable fall ends the transaction; data line toggled once as it falls
    task automatic close_frame();
        waitc(4);
        portEn = 1'b0;
        dBit   = ~dBit;
        waitc(6);
    endtask
endmodule

`default_nettype wire

// >>> verification/tb.sv
/*
 * Self-checking bench for the shift and readback block: writes, circular reads,
 * traffic while disabled. Assumes the controller model drives every pin.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;

    logic       core_clk = 1'b0;
    logic       reset_n  = 1'b0;
    wire  logic portEn, serClk, serData, cascadeOut, stackSel, frameAligned;
    logic [7:0] wiperZero, wiperOne, stackedWiper;
    logic [16:0] cur;
    logic        known;
    int          error_cnt  = 0;
    int          num_checks = 0;

    always #12.5 core_clk = ~core_clk;

    dcs_shift_readback dut (.core_clk(core_clk), .reset_n(reset_n), .portEn(portEn),
        .serClk(serClk), .serData(serData), .cascadeOut(cascadeOut),
        .wiperZero(wiperZero), .wiperOne(wiperOne), .stackSel(stackSel),
        .stackedWiper(stackedWiper), .frameAligned(frameAligned));
    dcs_ctl_model ctl (.core_clk(core_clk), .cascadeIn(cascadeOut), .portEn(portEn),
        .serClk(serClk), .serData(serData));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Wiper seen at the stacked output for a frame
    function automatic logic [7:0] exp_stacked(input logic [16:0] v);
        return v[16] ? v[15:8] : v[7:0];
    endfunction

    // Register after nb bits of v shifted in behind the old contents
    function automatic logic [16:0] exp_reg(input logic [16:0] old, input logic [16:0] v,
                                           input int nb);
        logic [33:0] cat;
        cat = {old, v};
        return cat[33-nb -: 17];
    endfunction

    task automatic check_hold(input logic [16:0] v, input logic al);
        check("wiperZero", wiperZero, v[7:0]);
        check("wiperOne", wiperOne, v[15:8]);
        check("stackSel", stackSel, v[16]);
        check("stackedWiper", stackedWiper, exp_stacked(v));
        check("cascadeIdle", cascadeOut, v[16]);
        check("frameAligned", frameAligned, al);
    endtask

    // Frame of nb bits of v, stack-select first; fb closes the feedback loop
    task automatic frame(input logic [16:0] v, input logic fb, input int nb);
        logic [16:0] nowReg;
        ctl.fbMode = fb;
        ctl.open_frame();
        if (known) check("cascadeOpen", cascadeOut, cur[16]);
        for (int k = 1; k <= nb; k++) begin
            ctl.clk_bit(v[17-k]);
            nowReg = exp_reg(cur, v, k);
            if (known) check("cascadeShift", cascadeOut, nowReg[16]);
            if (known && k == 16) check("cascadeMid", cascadeOut, cur[0]);
        end
        ctl.close_frame();
        ctl.fbMode = 1'b0;
        cur   = exp_reg(cur, v, nb);
        known = 1'b1;
        check_hold(cur, nb == 17);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h13d86ae1));
        known = 1'b0;
        cur   = 17'h0_0000;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        // Corner frames, each followed by a circular read
        frame(17'h1_FF00, 1'b0, 17);
        frame(17'h1_FF00, 1'b1, 17);
        frame(17'h0_00FF, 1'b0, 17);
        frame(17'h0_00FF, 1'b1, 17);
        for (int n = 0; n < 6; n++) begin
            frame(17'($urandom()), 1'b0, 17);
            frame(cur, 1'b1, 17);
            // Clock and data while disabled change nothing
            repeat (3) ctl.clk_bit(1'($urandom()));
            check_hold(cur, 1'b1);
            // Short frame loads a misaligned register; a circular read keeps it
            frame(17'($urandom()), 1'b0, 1 + int'($urandom_range(15)));
            frame(cur, 1'b1, 17);
        end
        results();
    end
endmodule

`default_nettype wire
